// ===== logic/ocf_pkg.sv
// Package: constants for the off-core response event filter
package ocf_pkg;

  // ----------------------------------------------------------------
  // Register addresses and widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CFG_W = 38;
  localparam logic [ADDR_W-1:0] ADDR_CFG_A = 12'h1a6;
  localparam logic [ADDR_W-1:0] ADDR_CFG_B = 12'h1a7;

  // ----------------------------------------------------------------
  // Event select encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] EVT_CODE_A = 8'hb7;
  localparam logic [7:0] EVT_CODE_B = 8'hbb;
  localparam logic [7:0] EVT_UMASK = 8'h01;
  localparam int unsigned NUM_CNT = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned REQ_LSB = 0;
  localparam int unsigned REQ_MSB = 15;
  localparam int unsigned SUP_LSB = 16;
  localparam int unsigned SUP_MSB = 30;
  localparam int unsigned SNP_LSB = 31;
  localparam int unsigned SNP_MSB = 37;
  localparam int unsigned ANY_BIT = 16;
  localparam int unsigned REQ_W = REQ_MSB - REQ_LSB + 1;
  localparam int unsigned SUP_W = SUP_MSB - SUP_LSB + 1;
  localparam int unsigned SNP_W = SNP_MSB - SNP_LSB + 1;

  // ----------------------------------------------------------------
  // Implemented bits; apart from the any bit (16), the rest are reserved and read zero
  // ----------------------------------------------------------------
  // Request: bits 0..11 and 15
  localparam logic [15:0] REQ_DEF_MASK = 16'h8fff;
  // Supplier without the any bit: bits 17..22 (field bits 1..6)
  localparam logic [14:0] SUP_DEF_MASK = 15'h007e;
  localparam logic [6:0] SNP_DEF_MASK = 7'h7f;
  localparam logic [37:0] CFG_RESET = 38'h00_0000_0000;

endpackage : ocf_pkg

// ===== logic/ocf_filter.sv
// Off-core response event filter with its two configuration registers
`timescale 1ns/1ns
module ocf_filter #(
  parameter int unsigned NUM_CNT = ocf_pkg::NUM_CNT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Configuration register port
  input wire logic cfg_wr_i,
  input wire logic [ocf_pkg::ADDR_W-1:0] cfg_addr_i,
  input wire logic [ocf_pkg::CFG_W-1:0] cfg_wdata_i,
  output logic [ocf_pkg::CFG_W-1:0] cfg_rdata_o,
  output logic cfg_hit_o,
  // Event select of each general counter
  input wire logic [NUM_CNT*8-1:0] evt_code_i,
  input wire logic [NUM_CNT*8-1:0] evt_umask_i,
  input wire logic [NUM_CNT-1:0] evt_en_i,
  // Completed off-core transaction report
  input wire logic txn_done_i,
  input wire logic [ocf_pkg::REQ_W-1:0] txn_req_i,
  input wire logic [ocf_pkg::SUP_W-1:0] txn_sup_i,
  input wire logic [ocf_pkg::SNP_W-1:0] txn_snp_i,
  // Counter increments and filter state
  output logic [NUM_CNT-1:0] general_counter_inc_o,
  output logic [1:0] filter_valid_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ocf_pkg::CFG_W-1:0] keep_defined(
    input logic [ocf_pkg::CFG_W-1:0] v
  );
    keep_defined = {v[ocf_pkg::SNP_MSB:ocf_pkg::SNP_LSB]
                      & ocf_pkg::SNP_DEF_MASK,
                    v[ocf_pkg::SUP_MSB:ocf_pkg::SUP_LSB]
                      & (ocf_pkg::SUP_DEF_MASK | 15'h0001),
                    v[ocf_pkg::REQ_MSB:ocf_pkg::REQ_LSB]
                      & ocf_pkg::REQ_DEF_MASK};
  endfunction : keep_defined

  function automatic logic filter_ok(
    input logic [ocf_pkg::CFG_W-1:0] c
  );
    logic req_ok;
    logic rsp_ok;
    req_ok = |c[ocf_pkg::REQ_MSB:ocf_pkg::REQ_LSB];
    rsp_ok = c[ocf_pkg::ANY_BIT]
           | ((|c[ocf_pkg::SUP_MSB:ocf_pkg::SUP_LSB+1])
              & (|c[ocf_pkg::SNP_MSB:ocf_pkg::SNP_LSB]));
    filter_ok = req_ok & rsp_ok;
  endfunction : filter_ok

  // Request classes are one bit each, so overlap of sets is the match
  function automatic logic txn_match(
    input logic [ocf_pkg::CFG_W-1:0] c,
    input logic [ocf_pkg::REQ_W-1:0] rq,
    input logic [ocf_pkg::SUP_W-1:0] sp,
    input logic [ocf_pkg::SNP_W-1:0] sn
  );
    logic req_hit;
    logic rsp_hit;
    req_hit = |(c[ocf_pkg::REQ_MSB:ocf_pkg::REQ_LSB] & rq);
    rsp_hit = c[ocf_pkg::ANY_BIT]
            | ((|(c[ocf_pkg::SUP_MSB:ocf_pkg::SUP_LSB]
                  & sp & ocf_pkg::SUP_DEF_MASK))
               & (|(c[ocf_pkg::SNP_MSB:ocf_pkg::SNP_LSB] & sn)));
    txn_match = filter_ok(c) & req_hit & rsp_hit;
  endfunction : txn_match

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [ocf_pkg::CFG_W-1:0] offcore_filter_config_a_r;
  logic [ocf_pkg::CFG_W-1:0] offcore_filter_config_b_r;

  // Reserved bits never stored, so they read zero and cannot match
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      offcore_filter_config_a_r <= ocf_pkg::CFG_RESET;
      offcore_filter_config_b_r <= ocf_pkg::CFG_RESET;
    end
    else if (cfg_wr_i)
    begin
      if (cfg_addr_i == ocf_pkg::ADDR_CFG_A)
      begin
        offcore_filter_config_a_r <= keep_defined(cfg_wdata_i);
      end
      if (cfg_addr_i == ocf_pkg::ADDR_CFG_B)
      begin
        offcore_filter_config_b_r <= keep_defined(cfg_wdata_i);
      end
    end
  end

  always_comb
  begin
    cfg_hit_o = 1'b1;
    case (cfg_addr_i)
      ocf_pkg::ADDR_CFG_A: cfg_rdata_o = offcore_filter_config_a_r;
      ocf_pkg::ADDR_CFG_B: cfg_rdata_o = offcore_filter_config_b_r;
      default:
      begin
        cfg_rdata_o = ocf_pkg::CFG_RESET;
        cfg_hit_o = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------
  logic match_a;
  logic match_b;

  // classes arrive as these bit positions
  always_comb
  begin
    match_a = txn_done_i & txn_match(offcore_filter_config_a_r,
      txn_req_i, txn_sup_i, txn_snp_i);
    match_b = txn_done_i & txn_match(offcore_filter_config_b_r,
      txn_req_i, txn_sup_i, txn_snp_i);
  end

  // ----------------------------------------------------------------
  // Counter routing, registered for timing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      general_counter_inc_o <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        general_counter_inc_o[i] <= evt_en_i[i]
          & (evt_umask_i[i*8 +: 8] == ocf_pkg::EVT_UMASK)
          & (((evt_code_i[i*8 +: 8] == ocf_pkg::EVT_CODE_A) & match_a)
           | ((evt_code_i[i*8 +: 8] == ocf_pkg::EVT_CODE_B) & match_b)
            );
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      filter_valid_o <= 2'b00;
    end
    else
    begin
      filter_valid_o <= {filter_ok(offcore_filter_config_b_r),
                         filter_ok(offcore_filter_config_a_r)};
    end
  end

endmodule : ocf_filter

// ===== tb/ocf_filter_sva.sv
// Assertion checker for the off-core response event filter
`timescale 1ns/1ns
module ocf_filter_sva #(
  parameter int unsigned NUM_CNT = 4
) (
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic [ocf_pkg::ADDR_W-1:0] cfg_addr_i,
  input wire logic [ocf_pkg::CFG_W-1:0] cfg_wdata_i,
  input wire logic [ocf_pkg::CFG_W-1:0] cfg_rdata_o,
  input wire logic cfg_hit_o,
  input wire logic [NUM_CNT*8-1:0] evt_code_i,
  input wire logic [NUM_CNT*8-1:0] evt_umask_i,
  input wire logic [NUM_CNT-1:0] evt_en_i,
  input wire logic txn_done_i,
  input wire logic [NUM_CNT-1:0] general_counter_inc_o,
  input wire logic [1:0] filter_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_inc_after_txn: assert property (
    |general_counter_inc_o |-> $past(txn_done_i)) else $error("stray inc");
  a_inc_enabled: assert property (
    (general_counter_inc_o & ~$past(evt_en_i)) == '0) else $error("inc off");
  a_umask_match: assert property (
    general_counter_inc_o[0] |-> $past(evt_umask_i[7:0]) == 8'h01)
    else $error("umask");
  a_code_match: assert property (
    general_counter_inc_o[0] |-> $past(evt_code_i[7:0]) inside {8'hb7, 8'hbb})
    else $error("code");
  a_hit_decode: assert property (
    cfg_hit_o == (cfg_addr_i inside {12'h1a6, 12'h1a7})) else $error("hit");
  a_rsvd_zero: assert property (
    cfg_rdata_o[14:12] == 3'h0 && cfg_rdata_o[30:23] == 8'h00)
    else $error("reserved bits");
  a_unmapped_zero: assert property (
    !cfg_hit_o |-> cfg_rdata_o == '0) else $error("unmapped data");
  // Same-address read only, a moved address reads another register
  a_write_readback: assert property (
    cfg_wr_i && cfg_hit_o |=> !$stable(cfg_addr_i) ||
    cfg_rdata_o == ($past(cfg_wdata_i) & 38'h3f_807f_8fff))
    else $error("readback");
  c_inc: cover property (general_counter_inc_o[0]);
  c_write: cover property (cfg_wr_i && cfg_hit_o);
  c_both_valid: cover property (filter_valid_o == 2'h3);
endmodule : ocf_filter_sva
bind ocf_filter ocf_filter_sva #(.NUM_CNT(NUM_CNT)) sva_u (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
  .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o), .evt_code_i(evt_code_i),
  .evt_umask_i(evt_umask_i), .evt_en_i(evt_en_i), .txn_done_i(txn_done_i),
  .general_counter_inc_o(general_counter_inc_o),
  .filter_valid_o(filter_valid_o));

// ===== tb/ocf_uncore_model.sv
// Model of the uncore completion reporting
`timescale 1ns/1ns
module ocf_uncore_model (
  // Clock
  input wire logic ref_clk_i,
  // Completion report
  output logic txn_done_o,
  output logic [15:0] txn_req_o,
  output logic [14:0] txn_sup_o,
  output logic [6:0] txn_snp_o
);
  initial txn_done_o = 1'b0;
  initial {txn_req_o, txn_sup_o, txn_snp_o} = 38'h0;
  // Lines turn over after the pulse so a stale value never matches
  task automatic send(input logic [15:0] q, input logic [14:0] p,
    input logic [6:0] s);
    @(negedge ref_clk_i);
    txn_done_o = 1'b1;
    {txn_req_o, txn_sup_o, txn_snp_o} = {q, p, s};
    @(negedge ref_clk_i);
    txn_done_o = 1'b0;
    {txn_req_o, txn_sup_o, txn_snp_o} = ~{q, p, s};
  endtask : send
endmodule : ocf_uncore_model

// ===== tb/tb.sv
// Testbench for the off-core response event filter
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic [11:0] cfg_addr_i = 12'h000;
  logic [37:0] cfg_wdata_i = 38'h0;
  logic [37:0] cfg_rdata_o, ca;
  logic cfg_hit_o, txn_done_i;
  logic [15:0] txn_req_i;
  logic [14:0] txn_sup_i;
  logic [6:0] txn_snp_i;
  logic [3:0] general_counter_inc_o;
  logic [1:0] filter_valid_o;
  int bad_count = 0;
  int cmp_count = 0;
  localparam logic [37:0] MASK = 38'h3f_807f_8fff;
  initial forever #50 ref_clk_i = ~ref_clk_i;
  // Counter 2 has a wrong umask, counter 3 is disabled
  ocf_filter dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o),
    .evt_code_i(32'hb7_b7_bb_b7), .evt_umask_i(32'h01_02_01_01),
    .evt_en_i(4'b0111), .txn_done_i(txn_done_i), .txn_req_i(txn_req_i),
    .txn_sup_i(txn_sup_i), .txn_snp_i(txn_snp_i),
    .general_counter_inc_o(general_counter_inc_o),
    .filter_valid_o(filter_valid_o));
  ocf_uncore_model um (.ref_clk_i(ref_clk_i), .txn_done_o(txn_done_i),
    .txn_req_o(txn_req_i), .txn_sup_o(txn_sup_i), .txn_snp_o(txn_snp_i));
  function automatic logic fv(input logic [37:0] c);
    return |(c[15:0] & 16'h8fff) && (c[16] || (|c[22:17] && |c[37:31]));
  endfunction : fv
  function automatic logic em(input logic [37:0] c, input logic [15:0] q,
    input logic [14:0] p, input logic [6:0] s);
    return fv(c) && |(c[15:0] & 16'h8fff & q) &&
      (c[16] || (|(c[22:17] & p[6:1]) && |(c[37:31] & s)));
  endfunction : em
  task automatic wr(input logic [11:0] a, input logic [37:0] d);
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [37:0] e);
    @(negedge ref_clk_i);
    cfg_addr_i = a;
    #1;
    `CHK("rdata", e, cfg_rdata_o)
    `CHK("hit", a inside {12'h1a6, 12'h1a7}, cfg_hit_o)
  endtask : rd
  task automatic check(input logic [37:0] a, input logic [37:0] b,
    input logic [15:0] q, input logic [14:0] p, input logic [6:0] s);
    logic [3:0] ei;
    ei = {2'b00, em(b, q, p, s), em(a, q, p, s)};
    wr(12'h1a6, a);
    wr(12'h1a7, b);
    rd(12'h1a6, a & MASK);
    rd(12'h1a7, b & MASK);
    um.send(q, p, s);
    `CHK("inc", ei, general_counter_inc_o)
    `CHK("valid", {fv(b), fv(a)}, filter_valid_o)
    @(negedge ref_clk_i);
    `CHK("inc_end", 4'h0, general_counter_inc_o)
  endtask : check
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    #300000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    repeat (4) @(negedge ref_clk_i);
    rst_i = 1'b0;
    rd(12'h1a6, 38'h0);
    $display("test reset done");
    wr(12'h1a5, {38{1'b1}});
    rd(12'h1a5, 38'h0);
    wr(12'h1a6, {38{1'b1}});
    rd(12'h1a6, MASK);
    rd(12'h1a7, 38'h0);
    $display("test registers done");
    // Every request bit alone, every snoop bit in turn
    for (int j = 0; j < 16; j++)
    begin
      ca = (38'h1 << j) | 38'h1_0000;
      check(ca, 38'h2_0001 | (38'h1 << (31 + j % 7)), (16'h1 << j) | 16'h1,
        15'h0002, 7'h1 << (j % 7));
    end
    check(38'h10_0004_8008, 38'h02_0004_8008,
      16'h0008, 15'h0004, 7'h20);
    check(38'h00_0040_0001, {38{1'b1}},
      16'h0800, 15'h0040, 7'h01);
    check(38'h00_7f81_0400, 38'h02_7f80_0001,
      16'h0400, 15'h7f80, 7'h00);
    check(38'h00_0004_0002, 38'h00_0004_8002,
      16'h0002, 15'h0004, 7'h01);
    $display("test matching done");
    wrap_up;
  end
endmodule : tb
